// [common/dms_consts.vh]
`ifndef DMS_CONSTS_VH
`define DMS_CONSTS_VH

// Operand and result geometry
`define DMS_OPW 16
`define DMS_HALFW 8
`define DMS_RESW 32
`define DMS_RES_HALF 16

// Reset values
`define DMS_OP_RST 16'h0000
`define DMS_ACC_HALF_RST 16'h0000
`define DMS_PROD_HALF_RST 16'h0000

// Accumulator input source selects
`define DMS_SRC_PROD 2'h0
`define DMS_SRC_AB 2'h1
`define DMS_SRC_CD 2'h2
`define DMS_SRC_ZERO 2'h3

`endif

// [hw/dms_operand_reg.v]
`timescale 1ns/1ps
`include "dms_consts.vh"

module dms_operand_reg #(
   parameter W = `DMS_OPW
) (
   ref_clk,
   sys_rst,
   slice_clock_gate,
   hold,
   clear,
   d,
   q
);
   input wire ref_clk;
   input wire sys_rst;
   input wire slice_clock_gate;
   input wire hold;
   input wire clear;
   input wire [W-1:0] d;
   output reg [W-1:0] q;

   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= {W{1'b0}};
      end else if (slice_clock_gate) begin // [RULE2]
         if (clear) begin
            q <= {W{1'b0}};
         end else if (!hold) begin // [RULE5]
            q <= d;
         end
      end
   end
endmodule

// [hw/dms_mac_slice.v]
// Functional notes
// RULE1: Every register in the slice is clocked by the one slice clock ref_clk.
// RULE2: The clock enable loads all slice registers when 1 and holds them all when 0.
// RULE3: Operands A and B are 16 bits, registered, and feed either the multiplier or the accumulator directly.
// RULE4: Operands C and D are 16 bits, registered, and feed only the accumulator directly.
// RULE5: Each operand register has a hold input, 1 keeps the value and 0 updates it.
// RULE6: The upper input clear zeroes the A and C registers and the upper multiplier pipeline stage.
// RULE7: The lower input clear zeroes B and D, the lower multiplier stage and the product register.
// RULE8: In full-width mode the output carries the 32-bit 16x16 product or MAC result.
// RULE9: In split mode the upper 8x8 result sits on bits 31:16 and the lower on bits 15:0.
// RULE10: The upper accumulator freeze holds accumulator bits 31:16 when 1.
// RULE11: The upper accumulator clear zeroes only accumulator bits 31:16.
// RULE12: Lower accumulator freeze and clear act the same way on bits 15:0 only.
// RULE13: In accumulate mode each enabled clock adds the new term to the held sum and drives it out.
`timescale 1ns/1ps
`include "dms_consts.vh"

module dms_mac_slice (
   ref_clk,
   sys_rst,
   slice_clock_gate,
   operand_a,
   operand_b,
   operand_c,
   operand_d,
   hold_operand_a_port,
   hold_operand_b_port,
   hold_operand_c_port,
   hold_operand_d_port,
   upper_input_clear_port,
   lower_input_clear_port,
   upper_acc_freeze_port,
   upper_acc_clear_port,
   lower_acc_freeze,
   lower_acc_clear,
   split_mode,
   accumulate_mode,
   acc_source,
   result
);
   input wire ref_clk;
   input wire sys_rst;
   input wire slice_clock_gate;
   input wire [`DMS_OPW-1:0] operand_a;
   input wire [`DMS_OPW-1:0] operand_b;
   input wire [`DMS_OPW-1:0] operand_c;
   input wire [`DMS_OPW-1:0] operand_d;
   input wire hold_operand_a_port;
   input wire hold_operand_b_port;
   input wire hold_operand_c_port;
   input wire hold_operand_d_port;
   input wire upper_input_clear_port;
   input wire lower_input_clear_port;
   input wire upper_acc_freeze_port;
   input wire upper_acc_clear_port;
   input wire lower_acc_freeze;
   input wire lower_acc_clear;
   input wire split_mode;
   input wire accumulate_mode;
   input wire [1:0] acc_source;
   output wire [`DMS_RESW-1:0] result;

   ////////////////////////////////////////////////////////////////////////////
   wire [`DMS_OPW-1:0] reg_a;
   wire [`DMS_OPW-1:0] reg_b;
   wire [`DMS_OPW-1:0] reg_c;
   wire [`DMS_OPW-1:0] reg_d;
   reg [`DMS_RES_HALF-1:0] pipe_hi;
   reg [`DMS_RES_HALF-1:0] pipe_lo;
   reg [`DMS_RESW-1:0] prod;
   reg [`DMS_RES_HALF-1:0] acc_hi;
   reg [`DMS_RES_HALF-1:0] acc_lo;
   reg [`DMS_RESW-1:0] next_term;
   reg [`DMS_RESW-1:0] next_sum;
   reg [`DMS_RESW:0] wide_sum;

   function [`DMS_RES_HALF-1:0] mul8;
      input [`DMS_HALFW-1:0] x;
      input [`DMS_HALFW-1:0] y;
      begin
         mul8 = x * y;
      end
   endfunction

   // Carry out of a half is dropped on purpose
   function [`DMS_RES_HALF-1:0] half_add;
      input [`DMS_RES_HALF-1:0] x;
      input [`DMS_RES_HALF-1:0] y;
      reg [`DMS_RES_HALF:0] s;
      begin
         s = {1'b0, x} + {1'b0, y};
         half_add = s[`DMS_RES_HALF-1:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Input registers, upper clear owns A and C, lower owns B and D
   dms_operand_reg #(.W(`DMS_OPW)) u_reg_a ( // [RULE3]
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .slice_clock_gate(slice_clock_gate),
      .hold(hold_operand_a_port), // [RULE5]
      .clear(upper_input_clear_port), // [RULE6]
      .d(operand_a),
      .q(reg_a)
   );

   dms_operand_reg #(.W(`DMS_OPW)) u_reg_b ( // [RULE3]
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .slice_clock_gate(slice_clock_gate),
      .hold(hold_operand_b_port), // [RULE5]
      .clear(lower_input_clear_port), // [RULE7]
      .d(operand_b),
      .q(reg_b)
   );

   dms_operand_reg #(.W(`DMS_OPW)) u_reg_c ( // [RULE4]
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .slice_clock_gate(slice_clock_gate),
      .hold(hold_operand_c_port), // [RULE5]
      .clear(upper_input_clear_port), // [RULE6]
      .d(operand_c),
      .q(reg_c)
   );

   dms_operand_reg #(.W(`DMS_OPW)) u_reg_d ( // [RULE4]
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .slice_clock_gate(slice_clock_gate),
      .hold(hold_operand_d_port), // [RULE5]
      .clear(lower_input_clear_port), // [RULE7]
      .d(operand_d),
      .q(reg_d)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Multiplier pipeline: partial products per half, then product register
   always @(posedge ref_clk or posedge sys_rst) begin // [RULE1]
      if (sys_rst) begin
         pipe_hi <= `DMS_PROD_HALF_RST;
      end else if (slice_clock_gate) begin // [RULE2]
         if (upper_input_clear_port) begin
            pipe_hi <= `DMS_PROD_HALF_RST; // [RULE6]
         end else begin
            pipe_hi <= mul8(reg_a[`DMS_OPW-1:`DMS_HALFW], reg_b[`DMS_OPW-1:`DMS_HALFW]);
         end
      end
   end

   always @(posedge ref_clk or posedge sys_rst) begin // [RULE1]
      if (sys_rst) begin
         pipe_lo <= `DMS_PROD_HALF_RST;
      end else if (slice_clock_gate) begin // [RULE2]
         if (lower_input_clear_port) begin
            pipe_lo <= `DMS_PROD_HALF_RST; // [RULE7]
         end else begin
            pipe_lo <= mul8(reg_a[`DMS_HALFW-1:0], reg_b[`DMS_HALFW-1:0]);
         end
      end
   end

   // Split path is one stage longer than the full-width path
   always @(posedge ref_clk or posedge sys_rst) begin // [RULE1]
      if (sys_rst) begin
         prod <= {`DMS_PROD_HALF_RST, `DMS_PROD_HALF_RST};
      end else if (slice_clock_gate) begin // [RULE2]
         if (lower_input_clear_port) begin
            prod <= {`DMS_PROD_HALF_RST, `DMS_PROD_HALF_RST}; // [RULE7]
         end else if (split_mode) begin
            prod <= {pipe_hi, pipe_lo}; // [RULE9]
         end else begin
            prod <= reg_a * reg_b; // [RULE8]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Adder input: product, or A:B / C:D directly
   always @* begin
      wide_sum = {1'b0, acc_hi, acc_lo} + {1'b0, next_term};
      case (acc_source)
         `DMS_SRC_PROD: next_term = prod;
         `DMS_SRC_AB: next_term = {reg_a, reg_b}; // [RULE3]
         `DMS_SRC_CD: next_term = {reg_c, reg_d}; // [RULE4]
         default: next_term = {`DMS_RESW{1'b0}};
      endcase
      // Split mode keeps the halves apart, no carry across bit 16
      if (split_mode) begin
         next_sum[`DMS_RESW-1:`DMS_RES_HALF] = half_add(acc_hi, next_term[`DMS_RESW-1:`DMS_RES_HALF]); // [RULE9]
         next_sum[`DMS_RES_HALF-1:0] = half_add(acc_lo, next_term[`DMS_RES_HALF-1:0]);
      end else begin
         wide_sum = {1'b0, acc_hi, acc_lo} + {1'b0, next_term};
         next_sum = wide_sum[`DMS_RESW-1:0]; // [RULE13]
      end
      if (!accumulate_mode) begin
         next_sum = next_term;
      end
   end

   always @(posedge ref_clk or posedge sys_rst) begin // [RULE1]
      if (sys_rst) begin
         acc_hi <= `DMS_ACC_HALF_RST;
      end else if (slice_clock_gate) begin // [RULE2]
         if (upper_acc_clear_port) begin
            acc_hi <= `DMS_ACC_HALF_RST; // [RULE11]
         end else if (!upper_acc_freeze_port) begin // [RULE10]
            acc_hi <= next_sum[`DMS_RESW-1:`DMS_RES_HALF];
         end
      end
   end

   always @(posedge ref_clk or posedge sys_rst) begin // [RULE1]
      if (sys_rst) begin
         acc_lo <= `DMS_ACC_HALF_RST;
      end else if (slice_clock_gate) begin // [RULE2]
         if (lower_acc_clear) begin
            acc_lo <= `DMS_ACC_HALF_RST; // [RULE12]
         end else if (!lower_acc_freeze) begin // [RULE12]
            acc_lo <= next_sum[`DMS_RES_HALF-1:0];
         end
      end
   end

   assign result = {acc_hi, acc_lo}; // [RULE8] [RULE13]
endmodule

// [bench/dms_slice_sva.sv]
`timescale 1ns/1ps
module dms_slice_sva (
   input wire ref_clk,
   input wire sys_rst,
   input wire slice_clock_gate,
   input wire upper_input_clear_port,
   input wire upper_acc_freeze_port,
   input wire upper_acc_clear_port,
   input wire lower_acc_freeze,
   input wire lower_acc_clear,
   input wire accumulate_mode,
   input wire [1:0] acc_source,
   input wire [31:0] result
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire g = slice_clock_gate;
   wire quiet = !upper_acc_freeze_port && !upper_acc_clear_port && !lower_acc_freeze && !lower_acc_clear;
   ////////////////////////////////////////////////////////////////
   chk_gate_stall: assert property (!g |=> $stable(result)) else $error("moved while disabled");
   chk_gate_long: assert property (!g [*2] |=> result == $past(result, 2)) else $error("drift");
   chk_hi_clear: assert property (g && upper_acc_clear_port |=> result[31:16] == 16'h0000)
      else $error("upper half not cleared");
   chk_lo_clear: assert property (g && lower_acc_clear |=> result[15:0] == 16'h0000)
      else $error("lower half not cleared");
   chk_hi_freeze: assert property (g && upper_acc_freeze_port && !upper_acc_clear_port
      |=> $stable(result[31:16])) else $error("upper half moved");
   chk_lo_freeze: assert property (g && lower_acc_freeze && !lower_acc_clear |=> $stable(result[15:0]))
      else $error("lower half moved");
   chk_zero_load: assert property ((g && quiet && !accumulate_mode && acc_source == 2'h3) [*3]
      |=> result == 32'h0) else $error("zero term not loaded");
   chk_a_clear: assert property ((g && upper_input_clear_port && quiet && !accumulate_mode
      && acc_source == 2'h1) [*3] |=> result[31:16] == 16'h0000) else $error("operand a not cleared");
   cover property (g && accumulate_mode);
   cover property (g && upper_acc_clear_port);
   cover property (!g);
endmodule
bind dms_mac_slice dms_slice_sva dms_slice_sva_i (.*);

// [bench/dms_fabric_sink.sv]
`timescale 1ns/1ps
module dms_fabric_sink (
   input wire ref_clk,
   input wire [31:0] result,
   output reg [31:0] seen
);
   // Fabric registers the slice output before use
   always @(posedge ref_clk) begin
      seen <= result;
   end
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
   reg ref_clk = 1'h0, sys_rst = 1'h1, slice_clock_gate = 1'h1, split_mode = 1'h0, accumulate_mode = 1'h0;
   reg [15:0] operand_a = 16'h0, operand_b = 16'h0, operand_c = 16'h0, operand_d = 16'h0;
   reg hold_operand_a_port = 1'h0, hold_operand_b_port = 1'h0, hold_operand_c_port = 1'h0, hold_operand_d_port = 1'h0;
   reg upper_input_clear_port = 1'h0, lower_input_clear_port = 1'h0, upper_acc_freeze_port = 1'h0;
   reg upper_acc_clear_port = 1'h0, lower_acc_freeze = 1'h0, lower_acc_clear = 1'h0;
   reg [1:0] acc_source = 2'h0;
   wire [31:0] result, seen;
   reg [31:0] lfsr = 32'h00012E73, e, f;
   integer n_fail = 0, samples_checked = 0, cyc = 0, k;
   dms_mac_slice dms_mac_slice_i (.*);
   dms_fabric_sink dms_fabric_sink_i (.ref_clk(ref_clk), .result(result), .seen(seen));
   ////////////////////////////////////////////////////////////////
   initial forever #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail = n_fail + 1;
         wrap_up;
      end
   end
   function [31:0] nx(input [31:0] s);
      nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task step(input integer n);
      repeat (n) @(negedge ref_clk);
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("unexpected at %0t: result %h, model %h", $time, got, exp);
      end
   endtask
   task wrap_up;
      $display("checked %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      step(4);
      sys_rst = 1'h0;
      for (k = 0; k < 6; k = k + 1) begin
         lfsr = nx(lfsr);
         {operand_a, operand_b} = lfsr;
         split_mode = k[0];
         step(6);
         e = split_mode ? (operand_a[15:8] * operand_b[15:8] << 16) + operand_a[7:0] * operand_b[7:0]
            : operand_a * operand_b;
         chk(result, e);
         chk(seen, e);
      end
      split_mode = 1'h0;
      lfsr = nx(lfsr);
      {operand_c, operand_d} = lfsr;
      for (k = 1; k < 5; k = k + 1) begin
         acc_source = k[1:0];
         step(5);
         chk(result, k == 1 ? {operand_a, operand_b} : k == 2 ? {operand_c, operand_d}
            : k == 4 ? operand_a * operand_b : 32'h0);
      end
      acc_source = 2'h1;
      e = {operand_a, operand_b};
      f = {operand_c, operand_d};
      {hold_operand_a_port, hold_operand_b_port, hold_operand_c_port, hold_operand_d_port} = 4'hF;
      lfsr = nx(lfsr);
      {operand_a, operand_b, operand_c, operand_d} = {lfsr, ~lfsr};
      step(5);
      chk(result, e);
      acc_source = 2'h2;
      step(5);
      chk(result, f);
      // Holds dropped with the gate low, so nothing may move
      slice_clock_gate = 1'h0;
      {hold_operand_a_port, hold_operand_b_port, hold_operand_c_port, hold_operand_d_port} = 4'h0;
      acc_source = 2'h1;
      step(5);
      chk(result, f);
      {slice_clock_gate, operand_a, operand_b} = {1'h1, 32'h00000003};
      step(5);
      {slice_clock_gate, accumulate_mode} = 2'h1;
      for (k = 0; k < 3; k = k + 1) begin
         slice_clock_gate = 1'h1;
         step(1);
         slice_clock_gate = 1'h0;
         step(1);
      end
      chk(result, 32'h0000000C);
      {slice_clock_gate, upper_acc_freeze_port, lower_acc_freeze} = 3'h7;
      step(3);
      chk(result, 32'h0000000C);
      {accumulate_mode, upper_acc_freeze_port, upper_acc_clear_port, operand_a, operand_b} = {3'h1, 32'h00050007};
      step(5);
      chk(result, 32'h0000000C);
      {upper_acc_clear_port, lower_acc_freeze, lower_acc_clear} = 3'h1;
      step(2);
      chk(result, 32'h00050000);
      {lower_acc_clear, upper_input_clear_port} = 2'h1;
      step(4);
      chk(result, 32'h00000007);
      lower_input_clear_port = 1'h1;
      step(4);
      chk(result, 32'h0);
      {upper_input_clear_port, lower_input_clear_port, operand_a, operand_b} = {2'h0, 32'h00030005};
      acc_source = 2'h0;
      step(5);
      chk(result, 32'h0000000F);
      sys_rst = 1'h1;
      step(1);
      chk(result, 32'h0);
      sys_rst = 1'h0;
      step(1);
      chk(result, 32'h0);
      step(3);
      chk(result, 32'h0000000F);
      wrap_up;
   end
endmodule
